/* File: rtl/apwt_pkg.sv */
// Operation
// RQ1: Underflow of period counter inverts output pin
// RQ2: Reload alternates primary and secondary, no pause
// RQ3: First interval after start is the primary
// RQ4: One-shot control register ignored in this mode
// RQ5: Source: clock, clock/2, clock/8, companion underflow
// RQ6: Primary lasts (n+1)(m+1) source cycles
// RQ7: Secondary lasts (n+1)(p+1) source cycles
// RQ8: Writing run bit one starts counting
// RQ9: Run bit zero or halt bit one stops
// RQ10: Interrupt with output change after secondary underflow
// RQ11: Prescaler and primary reads return live counters
// RQ12: Stopped writes load reload register and counter
// RQ13: Running writes load reload registers only
// RQ14: New periods take effect at next primary
// RQ15: Polarity bit picks primary and secondary levels
// RQ16: Source bit picks waveform or port latch
// RQ17: Source bit latched at start or interrupt
// RQ18: Reloads step with source and prescaler underflow
// RQ19: Interrupt request is one system-clock pulse
package apwt_pkg;

   // Register offsets, 4-bit address, 8-bit data
   localparam logic [3:0] APWT_OFS_RUN = 4'h0;
   localparam logic [3:0] APWT_OFS_ONESHOT = 4'h1;
   localparam logic [3:0] APWT_OFS_PINIO = 4'h2;
   localparam logic [3:0] APWT_OFS_SRC = 4'h3;
   localparam logic [3:0] APWT_OFS_PRESCALE = 4'h4;
   localparam logic [3:0] APWT_OFS_SECONDARY = 4'h5;
   localparam logic [3:0] APWT_OFS_PRIMARY = 4'h6;
   localparam logic [3:0] APWT_OFS_IRQ_STAT = 4'h7;
   localparam logic [3:0] APWT_OFS_IRQ_MASK = 4'h8;

   // Field positions
   localparam int APWT_RUN_BIT = 0;
   localparam int APWT_BUSY_BIT = 1;
   localparam int APWT_HALT_BIT = 2;
   localparam int APWT_POL_BIT = 0;
   localparam int APWT_OSRC_BIT = 2;

   // Count source encodings
   localparam logic [1:0] APWT_SRC_DIV1 = 2'h0;
   localparam logic [1:0] APWT_SRC_DIV2 = 2'h1;
   localparam logic [1:0] APWT_SRC_DIV8 = 2'h2;
   localparam logic [1:0] APWT_SRC_COMP = 2'h3;
   localparam logic [2:0] APWT_DIV8_LAST = 3'h7;

   typedef enum logic [1:0] {APWT_IDLE, APWT_PRIMARY, APWT_SECONDARY} apwt_phase_t;

   typedef struct packed {
      apwt_phase_t phase;
      logic [2:0] div_cnt;
      logic [7:0] pre_cnt;
      logic [7:0] pre_rel;
      logic [7:0] pre_act;
      logic [7:0] per_cnt;
      logic [7:0] prim_rel;
      logic [7:0] sec_rel;
      logic [7:0] sec_act;
      logic level;
      logic pol;
      logic osrc;
      logic osrc_lat;
      logic [1:0] clk_sel;
      logic [7:0] oneshot;
      logic irq_stat;
      logic irq_mask;
      logic irq;
      logic irq_pulse;
      logic pin;
      logic [7:0] rd_data;
   } apwt_state_t;

   // Reset values
   localparam logic [7:0] APWT_CNT_RST = 8'hff;
   localparam apwt_state_t APWT_STATE_RST = '{
      phase: APWT_IDLE, div_cnt: 3'h0, pre_cnt: APWT_CNT_RST, pre_rel: APWT_CNT_RST,
      pre_act: APWT_CNT_RST, per_cnt: APWT_CNT_RST, prim_rel: APWT_CNT_RST,
      sec_rel: APWT_CNT_RST, sec_act: APWT_CNT_RST, level: 1'b0, pol: 1'b0,
      osrc: 1'b0, osrc_lat: 1'b0, clk_sel: APWT_SRC_DIV1, oneshot: 8'h00,
      irq_stat: 1'b0, irq_mask: 1'b0, irq: 1'b0, irq_pulse: 1'b0, pin: 1'b0,
      rd_data: 8'h00};

endpackage

/* File: rtl/apwt_timer.sv */
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module apwt_timer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Count source and port latch
   input wire logic companion_uflow,
   input wire logic port_latch_bit,
   // Pin and interrupts
   output logic wave_out_pin,
   output logic irq,
   output logic irq_pulse
);
   import apwt_pkg::*;

   apwt_state_t st_r;
   apwt_state_t st_nxt;
   logic tick;
   logic per_uf;
   logic running;

   // Idle level equals polarity; primary drives the opposite
   function automatic logic idle_level(input logic pol);
      idle_level = pol;
   endfunction

   // Count source tick from the free-running divider, or the companion underflow
   always_comb begin
      case (st_r.clk_sel)
         APWT_SRC_DIV1: tick = 1'b1; // see RQ5
         APWT_SRC_DIV2: tick = st_r.div_cnt[0]; // see RQ5
         APWT_SRC_DIV8: tick = (st_r.div_cnt == APWT_DIV8_LAST); // see RQ5
         default: tick = companion_uflow; // see RQ5
      endcase
   end

   assign running = (st_r.phase != APWT_IDLE);

   // Next state of the whole block
   always_comb begin
      st_nxt = st_r;
      per_uf = 1'b0;
      st_nxt.div_cnt = st_r.div_cnt + 3'h1;
      st_nxt.irq_pulse = 1'b0;

      // Read data and clear-on-read of the status bit
      st_nxt.rd_data = 8'h00;
      if (reg_rd) begin
         if (reg_addr == APWT_OFS_RUN) begin
            st_nxt.rd_data[APWT_RUN_BIT] = running;
            st_nxt.rd_data[APWT_BUSY_BIT] = running;
         end else if (reg_addr == APWT_OFS_ONESHOT) begin
            st_nxt.rd_data = st_r.oneshot;
         end else if (reg_addr == APWT_OFS_PINIO) begin
            st_nxt.rd_data[APWT_POL_BIT] = st_r.pol;
            st_nxt.rd_data[APWT_OSRC_BIT] = st_r.osrc;
         end else if (reg_addr == APWT_OFS_SRC) begin
            st_nxt.rd_data[1:0] = st_r.clk_sel;
         end else if (reg_addr == APWT_OFS_PRESCALE) begin
            st_nxt.rd_data = st_r.pre_cnt; // see RQ11
         end else if (reg_addr == APWT_OFS_SECONDARY) begin
            st_nxt.rd_data = st_r.sec_rel;
         end else if (reg_addr == APWT_OFS_PRIMARY) begin
            st_nxt.rd_data = st_r.per_cnt; // see RQ11
         end else if (reg_addr == APWT_OFS_IRQ_STAT) begin
            st_nxt.rd_data[0] = st_r.irq_stat;
            st_nxt.irq_stat = 1'b0;
         end else if (reg_addr == APWT_OFS_IRQ_MASK) begin
            st_nxt.rd_data[0] = st_r.irq_mask;
         end
      end

      // Prescaler steps with the source, period with prescaler underflow
      if (running && tick) begin
         if (st_r.pre_cnt == 8'h00) begin
            st_nxt.pre_cnt = st_r.pre_act; // see RQ18 RQ6 RQ7
            if (st_r.per_cnt == 8'h00) begin
               per_uf = 1'b1;
               st_nxt.level = ~st_r.level; // see RQ1
               if (st_r.phase == APWT_PRIMARY) begin
                  st_nxt.per_cnt = st_r.sec_act; // see RQ2 RQ7
                  st_nxt.phase = APWT_SECONDARY;
               end else begin
                  // Snapshot reloads here so a running write waits for a primary
                  st_nxt.per_cnt = st_r.prim_rel; // see RQ2 RQ14
                  st_nxt.phase = APWT_PRIMARY;
                  st_nxt.pre_act = st_r.pre_rel; // see RQ14
                  st_nxt.pre_cnt = st_r.pre_rel; // see RQ14
                  st_nxt.sec_act = st_r.sec_rel; // see RQ14
                  st_nxt.irq_pulse = 1'b1; // see RQ10 RQ19
                  st_nxt.irq_stat = 1'b1; // see RQ10
                  st_nxt.osrc_lat = st_r.osrc; // see RQ17
               end
            end else begin
               st_nxt.per_cnt = st_r.per_cnt - 8'h01;
            end
         end else begin
            st_nxt.pre_cnt = st_r.pre_cnt - 8'h01;
         end
      end

      // Register writes
      if (reg_wr) begin
         if (reg_addr == APWT_OFS_RUN) begin
            if (reg_wdata[APWT_HALT_BIT]) begin
               st_nxt.phase = APWT_IDLE; // see RQ9
               st_nxt.level = idle_level(st_r.pol);
            end else if (reg_wdata[APWT_RUN_BIT] && !running) begin
               st_nxt.phase = APWT_PRIMARY; // see RQ8 RQ3
               st_nxt.per_cnt = st_r.prim_rel; // see RQ3
               st_nxt.pre_cnt = st_r.pre_rel;
               st_nxt.pre_act = st_r.pre_rel;
               st_nxt.sec_act = st_r.sec_rel;
               st_nxt.level = ~idle_level(st_r.pol); // see RQ15
               st_nxt.osrc_lat = st_r.osrc; // see RQ17
            end else if (!reg_wdata[APWT_RUN_BIT]) begin
               st_nxt.phase = APWT_IDLE; // see RQ9
               st_nxt.level = idle_level(st_r.pol);
            end
         end else if (reg_addr == APWT_OFS_ONESHOT) begin
            st_nxt.oneshot = reg_wdata; // see RQ4
         end else if (reg_addr == APWT_OFS_PINIO) begin
            st_nxt.pol = reg_wdata[APWT_POL_BIT]; // see RQ15
            st_nxt.osrc = reg_wdata[APWT_OSRC_BIT]; // see RQ16
            if (!running) begin
               st_nxt.level = idle_level(reg_wdata[APWT_POL_BIT]);
            end
         end else if (reg_addr == APWT_OFS_SRC) begin
            st_nxt.clk_sel = reg_wdata[1:0]; // see RQ5
         end else if (reg_addr == APWT_OFS_PRESCALE) begin
            st_nxt.pre_rel = reg_wdata; // see RQ13
            if (!running) begin
               st_nxt.pre_cnt = reg_wdata; // see RQ12
               st_nxt.pre_act = reg_wdata;
            end
         end else if (reg_addr == APWT_OFS_SECONDARY) begin
            st_nxt.sec_rel = reg_wdata; // see RQ13
            if (!running) begin
               st_nxt.sec_act = reg_wdata; // see RQ12
            end
         end else if (reg_addr == APWT_OFS_PRIMARY) begin
            st_nxt.prim_rel = reg_wdata; // see RQ13
            if (!running) begin
               st_nxt.per_cnt = reg_wdata; // see RQ12
            end
         end else if (reg_addr == APWT_OFS_IRQ_MASK) begin
            st_nxt.irq_mask = reg_wdata[0];
         end
      end

      // Outputs from the next state, so each port is a flop
      st_nxt.irq = st_nxt.irq_stat & st_nxt.irq_mask;
      st_nxt.pin = st_nxt.osrc_lat ? port_latch_bit : st_nxt.level; // see RQ16
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= APWT_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rd_data;
   assign wave_out_pin = st_r.pin;
   assign irq = st_r.irq;
   assign irq_pulse = st_r.irq_pulse;

   // Checks on the block's own behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   underflow_toggle_a: assert property ( // see RQ1
      per_uf && !reg_wr |=> st_r.level != $past(st_r.level))
      else $error("output level did not invert on underflow");

   alternate_reload_a: assert property ( // see RQ2
      per_uf && !reg_wr && st_r.phase == APWT_PRIMARY
      |=> st_r.phase == APWT_SECONDARY && st_r.per_cnt == $past(st_r.sec_act))
      else $error("secondary value not reloaded after primary");

   start_primary_a: assert property ( // see RQ3
      reg_wr && reg_addr == APWT_OFS_RUN && reg_wdata[APWT_RUN_BIT] && !reg_wdata[APWT_HALT_BIT] && !running
      |=> st_r.phase == APWT_PRIMARY && st_r.per_cnt == $past(st_r.prim_rel))
      else $error("start did not begin with primary value");

   oneshot_ignored_a: assert property ( // see RQ4
      reg_wr && reg_addr == APWT_OFS_ONESHOT && !per_uf |=> st_r.phase == $past(st_r.phase))
      else $error("one-shot write changed the phase");

   div8_source_a: assert property ( // see RQ5
      st_r.clk_sel == APWT_SRC_DIV8 && tick |-> st_r.div_cnt == 3'h7)
      else $error("divide-by-eight tick misplaced");

   prescale_reload_a: assert property ( // see RQ6
      running && tick && st_r.pre_cnt == 8'h00 && !per_uf && !reg_wr
      |=> st_r.pre_cnt == $past(st_r.pre_act))
      else $error("prescaler did not reload on underflow");

   irq_with_edge_a: assert property ( // see RQ10
      per_uf && !reg_wr && st_r.phase == APWT_SECONDARY
      |=> st_r.irq_pulse && wave_out_pin == (st_r.osrc_lat ? $past(port_latch_bit) : st_r.level))
      else $error("interrupt not raised with secondary underflow");

   live_read_a: assert property ( // see RQ11
      reg_rd && reg_addr == APWT_OFS_PRIMARY |=> reg_rdata == $past(st_r.per_cnt))
      else $error("primary read did not return live counter");

   halt_stops_a: assert property ( // see RQ9
      reg_wr && reg_addr == APWT_OFS_RUN && reg_wdata[APWT_HALT_BIT] |=> !running ##1 (!running || $past(reg_wr)))
      else $error("forced halt did not stop counting");

   running_write_a: assert property ( // see RQ13
      reg_wr && reg_addr == APWT_OFS_PRIMARY && running && !tick
      |=> st_r.per_cnt == $past(st_r.per_cnt) && st_r.prim_rel == $past(reg_wdata))
      else $error("running write touched the period counter");

   irq_single_a: assert property ( // see RQ19
      irq_pulse |=> !irq_pulse)
      else $error("interrupt pulse longer than one cycle");

   // Reload, start and stop; writes excluded where they legally override
   second_reload_a: assert property ( // see RQ2
      per_uf && !reg_wr && st_r.phase == APWT_SECONDARY
      |=> st_r.phase == APWT_PRIMARY && st_r.per_cnt == $past(st_r.prim_rel))
      else $error("primary value not reloaded after secondary");

   count_continues_a: assert property ( // see RQ2
      per_uf && !reg_wr |=> running)
      else $error("counting paused after underflow");

   start_needs_write_a: assert property ( // see RQ8
      !running && !(reg_wr && reg_addr == APWT_OFS_RUN) |=> !running)
      else $error("counting began without a start write");

   stop_on_clear_a: assert property ( // see RQ9
      reg_wr && reg_addr == APWT_OFS_RUN && !reg_wdata[APWT_RUN_BIT] |=> !running)
      else $error("run bit zero did not stop counting");

   idle_frozen_a: assert property ( // see RQ9
      !running && !reg_wr |=> st_r.per_cnt == $past(st_r.per_cnt) && st_r.pre_cnt == $past(st_r.pre_cnt))
      else $error("counters moved while stopped");

   // Interrupt and status
   irq_source_a: assert property ( // see RQ10
      irq_pulse |-> $past(per_uf) && $past(st_r.phase) == APWT_SECONDARY)
      else $error("interrupt pulse without secondary underflow");

   irq_sets_status_a: assert property ( // see RQ10
      irq_pulse |-> st_r.irq_stat)
      else $error("interrupt pulse did not set status");

   irq_level_a: assert property ( // see RQ10
      st_r.irq_stat && st_r.irq_mask |-> irq)
      else $error("unmasked status did not raise interrupt");

   stat_cleared_a: assert property ( // see RQ10
      reg_rd && reg_addr == APWT_OFS_IRQ_STAT && !per_uf |=> !st_r.irq_stat)
      else $error("status read did not clear the bit");

   // Register reads and writes
   live_prescale_a: assert property ( // see RQ11
      reg_rd && reg_addr == APWT_OFS_PRESCALE |=> reg_rdata == $past(st_r.pre_cnt))
      else $error("prescaler read did not return live counter");

   rdata_idle_a: assert property ( // see RQ11
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without a read");

   stopped_primary_a: assert property ( // see RQ12
      reg_wr && reg_addr == APWT_OFS_PRIMARY && !running
      |=> st_r.per_cnt == $past(reg_wdata) && st_r.prim_rel == $past(reg_wdata))
      else $error("stopped primary write missed the counter");

   stopped_prescale_a: assert property ( // see RQ12
      reg_wr && reg_addr == APWT_OFS_PRESCALE && !running
      |=> st_r.pre_cnt == $past(reg_wdata) && st_r.pre_act == $past(reg_wdata))
      else $error("stopped prescaler write missed the counter");

   stopped_secondary_a: assert property ( // see RQ12
      reg_wr && reg_addr == APWT_OFS_SECONDARY && !running |=> st_r.sec_act == $past(reg_wdata))
      else $error("stopped secondary write missed the counter");

   running_prescale_a: assert property ( // see RQ13
      reg_wr && reg_addr == APWT_OFS_PRESCALE && running && !tick
      |=> st_r.pre_cnt == $past(st_r.pre_cnt) && st_r.pre_rel == $past(reg_wdata))
      else $error("running write touched the prescaler");

   running_secondary_a: assert property ( // see RQ13
      reg_wr && reg_addr == APWT_OFS_SECONDARY && running && !per_uf
      |=> st_r.sec_act == $past(st_r.sec_act) && st_r.sec_rel == $past(reg_wdata))
      else $error("running write touched the secondary value");

   snapshot_hold_a: assert property ( // see RQ14
      running && !per_uf && !reg_wr
      |=> st_r.pre_act == $past(st_r.pre_act) && st_r.sec_act == $past(st_r.sec_act))
      else $error("active values changed outside a primary start");

   // Pin routing and level
   primary_level_a: assert property ( // see RQ15
      reg_wr && reg_addr == APWT_OFS_RUN && reg_wdata[APWT_RUN_BIT] && !reg_wdata[APWT_HALT_BIT] && !running
      |=> st_r.level == !$past(st_r.pol))
      else $error("primary level does not follow polarity");

   idle_level_a: assert property ( // see RQ15
      reg_wr && reg_addr == APWT_OFS_RUN && !reg_wdata[APWT_RUN_BIT] |=> st_r.level == $past(st_r.pol))
      else $error("stop did not return the idle level");

   latch_route_a: assert property ( // see RQ16
      st_r.osrc_lat |-> wave_out_pin == $past(port_latch_bit))
      else $error("pin does not carry the port latch");

   wave_route_a: assert property ( // see RQ16
      !st_r.osrc_lat |-> wave_out_pin == st_r.level)
      else $error("pin does not carry the waveform");

   osrc_hold_a: assert property ( // see RQ17
      !per_uf && !(reg_wr && reg_addr == APWT_OFS_RUN) |=> st_r.osrc_lat == $past(st_r.osrc_lat))
      else $error("output source changed outside start or interrupt");

   // Count source and pacing
   div2_source_a: assert property ( // see RQ5
      st_r.clk_sel == APWT_SRC_DIV2 |-> tick == st_r.div_cnt[0])
      else $error("divide-by-two tick misplaced");

   comp_source_a: assert property ( // see RQ5
      st_r.clk_sel == APWT_SRC_COMP |-> tick == companion_uflow)
      else $error("companion tick not followed");

   clock_hold_a: assert property ( // see RQ18
      running && !tick && !reg_wr
      |=> st_r.per_cnt == $past(st_r.per_cnt) && st_r.pre_cnt == $past(st_r.pre_cnt))
      else $error("counter moved without a source tick");

   period_step_a: assert property ( // see RQ18
      running && tick && st_r.pre_cnt != 8'h00 && !reg_wr |=> st_r.per_cnt == $past(st_r.per_cnt))
      else $error("period moved without prescaler underflow");

endmodule
`default_nettype wire

/* File: test/apwt_pin_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side receiver: measures how long the pin sits at each level
module apwt_pin_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Observed pin
   input wire logic wave_out_pin,
   // Last completed level lengths, in system clocks
   output logic [15:0] high_len,
   output logic [15:0] low_len
);
   logic [15:0] run_r;
   logic last_r;
   // Length closes on each edge of the pin; a stuck pin leaves old values
   always_ff @(posedge sys_clk) begin
      last_r <= wave_out_pin;
      if (sys_rst) begin
         run_r <= 16'h0001;
         high_len <= 16'h0000;
         low_len <= 16'h0000;
      end else if (wave_out_pin != last_r) begin
         if (last_r) high_len <= run_r;
         else low_len <= run_r;
         run_r <= 16'h0001;
      end else begin
         run_r <= run_r + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import apwt_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic companion_uflow = 1'b0, port_latch_bit = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d, n, m, p;
   logic wave_out_pin, irq, irq_pulse;
   logic [15:0] high_len, low_len;
   int seed, n_mismatch, checks_done, cyc, s, k;
   // Device under test and pin receiver
   apwt_timer DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .companion_uflow(companion_uflow),
      .port_latch_bit(port_latch_bit), .wave_out_pin(wave_out_pin), .irq(irq), .irq_pulse(irq_pulse));
   apwt_pin_monitor MON (.sys_clk(sys_clk), .sys_rst(sys_rst), .wave_out_pin(wave_out_pin),
      .high_len(high_len), .low_len(low_len));
   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;
   // Companion ticks every third cycle; timeout guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      companion_uflow <= (cyc % 3 == 0);
      if (cyc == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // Expected level length: prescale times period times source division
   function automatic logic [15:0] exp_len(logic [7:0] pn, logic [7:0] pv, int src);
      int dv;
      dv = (src == 0) ? 1 : (src == 1) ? 2 : (src == 2) ? 8 : 3;
      return 16'((pn + 1) * (pv + 1) * dv);
   endfunction
   task automatic check(logic [15:0] got, logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle register strobes, driven right after the edge
   task automatic wr(logic [3:0] a, logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // Data stand for one cycle; taken at the edge that ends it
      @(posedge sys_clk);
      v = reg_rdata;
   endtask
   task automatic report_and_stop();
      $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      seed = 4;
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      wr(APWT_OFS_IRQ_MASK, 8'h01);
      // Every count source, random small periods, then a live period change
      for (s = 0; s < 4; s++) begin
         n = 8'($random(seed) & 3);
         m = 8'($random(seed) & 3);
         p = 8'($random(seed) & 3);
         wr(APWT_OFS_RUN, 8'h00);
         wr(APWT_OFS_PINIO, 8'(s & 1));
         wr(APWT_OFS_PRESCALE, n);
         wr(APWT_OFS_SECONDARY, p);
         wr(APWT_OFS_PRIMARY, m);
         wr(APWT_OFS_SRC, 8'(s));
         wr(APWT_OFS_ONESHOT, 8'h5a);
         rd(APWT_OFS_PRIMARY, d);
         check(16'(d), 16'(m));
         wr(APWT_OFS_RUN, 8'h01);
         repeat (700) @(posedge sys_clk);
         check(high_len, exp_len(n, (s & 1) ? p : m, s));
         check(low_len, exp_len(n, (s & 1) ? m : p, s));
         m = 8'($random(seed) & 3);
         wr(APWT_OFS_PRIMARY, m);
         repeat (700) @(posedge sys_clk);
         check((s & 1) ? low_len : high_len, exp_len(n, m, s));
         // Interrupt pulse arrives with the change to the primary level
         for (k = 0; k < 300 && irq_pulse !== 1'b1; k++) @(posedge sys_clk);
         check(16'({irq_pulse, wave_out_pin}), 16'({1'b1, 1'(~s & 1)}));
      end
      check(16'(irq), 16'h0001);
      // Forced halt, then sticky status cleared by read
      wr(APWT_OFS_RUN, 8'h05);
      rd(APWT_OFS_RUN, d);
      check(16'(d[0]), 16'h0000);
      rd(APWT_OFS_IRQ_STAT, d);
      check(16'(d), 16'h0001);
      rd(APWT_OFS_IRQ_STAT, d);
      check(16'(d), 16'h0000);
      check(16'(irq), 16'h0000);
      rd(APWT_OFS_ONESHOT, d);
      check(16'(d), 16'h005a);
      rd(4'hf, d);
      check(16'(d), 16'h0000);
      // Pin handed to the port latch at start
      port_latch_bit <= 1'($random(seed));
      wr(APWT_OFS_PINIO, 8'h04);
      wr(APWT_OFS_RUN, 8'h01);
      repeat (60) @(posedge sys_clk);
      check(16'(wave_out_pin), 16'(port_latch_bit));
      report_and_stop();
   end
endmodule
`default_nettype wire
